// ==== bench/profile_position_sequencer_tb.sv ====
`timescale 1ns/1ps

module profile_position_sequencer_tb;
    import pp_seq_pkg::*;
    logic core_clk, sys_rst, wrap_enable, press_detect, done, start, abort, push_act, stop_pin;
    logic [15:0] ctrl_word, sw;
    logic [31:0] target_pos, cmd_pos, act_pos;
    logic [1:0] wrap_mode;
    logic [7:0] lat;
    move_cmd_t mc;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    // ==========================================
    // Design and far side
    profile_position_sequencer uut (.core_clk(core_clk), .sys_rst(sys_rst),
        .ctrl_word(ctrl_word), .target_pos(target_pos), .profile_vel(32'h0000_1234),
        .wrap_enable(wrap_enable), .wrap_mode(wrap_mode), .wrap_range(16'h000A),
        .wrap_offset(16'h1388), .op_enabled(1'b1), .stop_pin(stop_pin), .cmd_pos(cmd_pos),
        .act_pos(act_pos), .press_detect(press_detect), .drive_status_in(16'h0000),
        .traj_done(done), .move_start_ff(start), .move_abort_ff(abort),
        .move_cmd_ff(mc), .status_word_ff(sw), .push_active_ff(push_act));
    traj_model far_end (.core_clk(core_clk), .sys_rst(sys_rst), .start(start),
        .abort(abort), .lat(lat), .done_ff(done));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // A hang counts as a mismatch and still reaches the verdict.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            wrap_up();
        end
    end

    // ==========================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // A queued setpoint is acknowledged although it starts nothing yet.
    task automatic launch(input logic [15:0] cw, input logic go, input logic acked);
        @(posedge core_clk);
        ctrl_word <= cw | 16'h0010;
        @(posedge core_clk);
        #1;
        check(32'(start), 32'(go));
        @(posedge core_clk);
        ctrl_word <= cw;
        #1;
        check(32'(sw[12]), 32'(acked));
    endtask

    task automatic wait_pulse();
        for (int i = 0; i < 300; i++) begin
            @(posedge core_clk);
            #1;
            if (done === 1'b1) begin
                break;
            end
        end
    endtask

    task automatic wait_done();
        wait_pulse();
        repeat (2) @(posedge core_clk);
        #1;
        check(32'(sw[10]), 32'h1);
    endtask

    // ==========================================
    // Scenarios
    task automatic t_plain();
        target_pos <= 32'd4000;
        launch(16'h0000, 1'b1, 1'b1);
        check(32'(mc.kind), 32'(KIND_ABS));
        check(mc.dest, 32'd4000);
        check(32'(sw[10]), 32'h0);
        wait_done();
        target_pos <= 32'd3000;
        launch(16'h0040, 1'b1, 1'b1);
        check(mc.dest, 32'd4000);
        wait_done();
        launch(16'h1040, 1'b1, 1'b1);
        check(32'(mc.kind), 32'(KIND_INC_FB));
        check(mc.dest, 32'd3900);
        wait_done();
        $display("test plain moves done");
    endtask

    task automatic t_wrap();
        launch(16'h4000, 1'b0, 1'b0);
        wrap_enable <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            wrap_mode <= 2'(m);
            launch(16'h4040, 1'b1, 1'b1);
            check(32'(mc.kind), 32'(m + 3));
            check({mc.wrap_range, mc.wrap_offset}, 32'h000A_1388);
            wait_done();
        end
        $display("test wrap modes done");
    endtask

    task automatic t_queue();
        lat <= 8'd30;
        launch(16'h0000, 1'b1, 1'b1);
        target_pos <= 32'd111;
        launch(16'h0000, 1'b0, 1'b1);
        target_pos <= 32'd222;
        launch(16'h0000, 1'b0, 1'b1);
        wait_pulse();
        @(posedge core_clk);
        #1;
        check(32'(start), 32'h1);
        check(mc.dest, 32'd222);
        @(posedge core_clk);
        #1;
        check(32'(sw[10]), 32'h0);
        wait_done();
        launch(16'h0020, 1'b1, 1'b1);
        target_pos <= 32'd333;
        launch(16'h0020, 1'b1, 1'b1);
        check(mc.dest, 32'd333);
        wait_done();
        $display("test queue and replace done");
    endtask

    task automatic t_push();
        lat <= 8'd60;
        launch(16'h2000, 1'b1, 1'b1);
        check({30'h0, mc.push, mc.rect_profile}, 32'h3);
        check(mc.velocity, 32'h0000_1234);
        press_detect <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        check(32'(sw[15]), 32'h1);
        ctrl_word <= 16'h2100;
        @(posedge core_clk);
        #1;
        check({30'h0, abort, push_act}, 32'h2);
        press_detect <= 1'b0;
        wait_done();
        ctrl_word <= 16'h0000;
        lat <= 8'd8;
        launch(16'h2000, 1'b1, 1'b1);
        wait_done();
        check(32'(sw[15]), 32'h0);
        // The stop input passes two flip-flops and the abort register one more, so the abort comes three cycles later.
        lat <= 8'd60;
        launch(16'h2000, 1'b1, 1'b1);
        stop_pin <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check({30'h0, abort, push_act}, 32'h2);
        stop_pin <= 1'b0;
        wait_pulse();
        repeat (2) @(posedge core_clk);
        #1;
        check(32'(sw[10]), 32'h0);
        $display("test push done");
    endtask

    task automatic wrap_up();
        $display("checked %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        sys_rst = 1'b1;
        ctrl_word = 16'h0000;
        target_pos = 32'd0;
        cmd_pos = 32'd1000;
        act_pos = 32'd900;
        wrap_enable = 1'b0;
        wrap_mode = 2'h0;
        press_detect = 1'b0;
        stop_pin = 1'b0;
        lat = 8'd5;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_plain();
        t_wrap();
        t_queue();
        t_push();
        wrap_up();
    end
endmodule

// ==== bench/traj_model.sv ====
`timescale 1ns/1ps

// ==========================================
// Trajectory generator stand-in
module traj_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Move commands
    input wire logic start,
    input wire logic abort,
    input wire logic [7:0] lat,
    // Completion
    output logic done_ff
);
    logic [7:0] left_ff;

    // A replace reloads the count, so a replaced move never finishes early.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            left_ff <= 8'h00;
        end else if (abort) begin
            left_ff <= 8'h02;
        end else if (start) begin
            left_ff <= lat;
        end else if (left_ff != 8'h00) begin
            left_ff <= left_ff - 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        done_ff <= !sys_rst && !start && !abort && left_ff == 8'h01;
    end
endmodule

// ==== hw/cmd_store.sv ====
`timescale 1ns/1ps

module cmd_store #(
    parameter int WIDTH = 38
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Write side
    input wire logic wr,
    input wire logic [WIDTH-1:0] wr_data,
    // Read side
    input wire logic clr,
    output logic valid,
    output logic [WIDTH-1:0] rd_data
);

    // ======================================================================
    // Single slot
    // A write in the same cycle as a clear keeps the new command.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            valid <= 1'b0;
        end else if (wr) begin
            valid <= 1'b1; // see (RQ22)
        end else if (clr) begin
            valid <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_data <= '0;
        end else if (wr) begin
            rd_data <= wr_data; // see (RQ22)
        end
    end

endmodule

// ==== hw/pp_seq_pkg.sv ====
package pp_seq_pkg;

    // ======================================================================
    // Move variants
    typedef enum logic [2:0] {
        KIND_ABS,
        KIND_INC_CMD,
        KIND_INC_FB,
        KIND_WRAP_ABS,
        KIND_WRAP_PROX,
        KIND_WRAP_FWD,
        KIND_WRAP_REV
    } move_kind_t;

    // ======================================================================
    // Raw setpoint as latched from the control objects
    typedef struct packed {
        logic [31:0] target;
        logic abs_rel;
        logic base_fb;
        logic push;
        logic wrap;
        logic [1:0] wrap_mode;
    } request_t;

    // ======================================================================
    // Resolved move handed to the trajectory generator
    typedef struct packed {
        move_kind_t kind;
        logic push;
        logic rect_profile;
        logic [31:0] dest;
        logic [31:0] velocity;
        logic [15:0] wrap_range;
        logic [15:0] wrap_offset;
    } move_cmd_t;

endpackage

// ==== hw/pp_seq_regs.svh ====
// Notes on behaviour
// (RQ1) Master loads target first; device starts a move when new-setpoint bit rises.
// (RQ2) Change-immediately set: a setpoint during motion replaces the running move at once.
// (RQ3) Change-immediately clear: a setpoint during motion is stored, started after completion.
// (RQ4) Push bit set before new-setpoint: device starts a push-motion move instead.
// (RQ5) Push moves are self-start, rectangular, no ramp, at profile velocity.
// (RQ6) During push motion, press-contact status bit goes high once pressing a load.
// (RQ7) Halt bit or stop input during push motion stops the move, cancels push.
// (RQ8) Push move reaching target without contact completes normally, press-contact stays low.
// (RQ9) Wrap bit set at setpoint: wrap absolute-type move, absolute/relative bit ignored.
// (RQ10) Master enables wrap setting before any wrap move; otherwise wrap moves are refused.
// (RQ11) Wrap clear: abs/rel bit 0 absolute, 1 incremental; base bit picks command/feedback.
// (RQ12) Wrap set: mode 0 absolute, 1 proximity, 2 forward, 3 reverse; push independent.
// (RQ13) Absolute: target is a home-referenced coordinate, reached from present position.
// (RQ14) Incremental on command: destination is command position plus target distance.
// (RQ15) Incremental on feedback: destination is actual position plus target distance.
// (RQ16) Wrap absolute: move to a target coordinate inside the wrap range.
// (RQ17) Wrap proximity: reach the target along the shorter rotational direction.
// (RQ18) Wrap range is in 0.1 rev units, offset ratio in 0.01 percent units.
// (RQ19) Setpoint-acknowledge sets on accepted start, clears on bit low or leaving operation.
// (RQ20) With halt clear, target-reached sets on proper completion, clears on new move.
// (RQ21) Only the rising edge of new-setpoint is a start event.
// (RQ22) At most one queued command; a later one overwrites it until completion.
`ifndef PP_SEQ_REGS_SVH
`define PP_SEQ_REGS_SVH

// ==========================================================================
// Object indices
`define CONTROL_WORD_IDX 16'h6040
`define STATUS_WORD_IDX 16'h6041

// ==========================================================================
// Control word fields
`define CW_NEW_SETPOINT 4
`define CW_CHANGE_NOW 5
`define CW_ABS_REL 6
`define CW_HALT 8
`define CW_INC_BASE 12
`define CW_PUSH 13
`define CW_WRAP 14

// ==========================================================================
// Status word fields and reset
`define SW_TARGET_REACHED 10
`define SW_SETPOINT_ACK 12
`define SW_PRESS_CONTACT 15
`define STATUS_WORD_RESET 16'h0000

// ==========================================================================
// Wrap positioning mode codes
`define WRAP_MODE_ABS 2'h0
`define WRAP_MODE_PROX 2'h1
`define WRAP_MODE_FWD 2'h2
`define WRAP_MODE_REV 2'h3

// ==========================================================================
// Units of the wrap objects
`define WRAP_RANGE_UNIT_MREV 100
`define WRAP_OFFSET_UNIT_PPM 100

`endif

// ==== hw/profile_position_sequencer.sv ====
`timescale 1ns/1ps
`include "pp_seq_regs.svh"

module profile_position_sequencer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Control objects from the fieldbus
    input wire logic [15:0] ctrl_word,
    input wire logic [31:0] target_pos,
    input wire logic [31:0] profile_vel,
    input wire logic wrap_enable,
    input wire logic [1:0] wrap_mode,
    input wire logic [15:0] wrap_range,
    input wire logic [15:0] wrap_offset,
    // Drive state and feedback
    input wire logic op_enabled,
    input wire logic stop_pin,
    input wire logic [31:0] cmd_pos,
    input wire logic [31:0] act_pos,
    input wire logic press_detect,
    input wire logic [15:0] drive_status_in,
    // Trajectory generator
    input wire logic traj_done,
    output logic move_start_ff,
    output logic move_abort_ff,
    output pp_seq_pkg::move_cmd_t move_cmd_ff,
    // Status
    output logic [15:0] status_word_ff,
    output logic push_active_ff
);
    import pp_seq_pkg::*;

    // ======================================================================
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MOVING,
        ST_STOPPING
    } seq_state_t;

    seq_state_t state_ff;
    logic stop_meta_ff;
    logic stop_sync_ff;
    logic new_sp_prev_ff;
    logic ack_ff;
    logic reached_ff;
    logic press_ff;
    logic pend_valid;
    request_t pend_req;
    request_t req;
    request_t launch_req;
    move_cmd_t launch_cmd;
    logic new_sp_evt;
    logic halt;
    logic stop_cond;
    logic wrap_ok;
    logic accept;
    logic in_idle;
    logic in_move;
    logic in_stop;
    logic abort_now;
    logic idle_launch;
    logic imm_launch;
    logic done_launch;
    logic launch;
    logic use_pend;
    logic queue_wr;
    logic taken;
    logic [31:0] inc_cmd_sum;
    logic [31:0] inc_fb_sum;

    // ======================================================================
    // Stop input synchroniser
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stop_meta_ff <= 1'b0;
            stop_sync_ff <= 1'b0;
        end else begin
            stop_meta_ff <= stop_pin;
            stop_sync_ff <= stop_meta_ff;
        end
    end

    // ======================================================================
    // Setpoint edge and request decode
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            new_sp_prev_ff <= 1'b0;
        end else begin
            new_sp_prev_ff <= ctrl_word[`CW_NEW_SETPOINT];
        end
    end

    // Holding the bit high yields one event only.
    assign new_sp_evt = ctrl_word[`CW_NEW_SETPOINT] & ~new_sp_prev_ff; // see (RQ21) (RQ1)
    assign halt = ctrl_word[`CW_HALT];
    assign stop_cond = halt | stop_sync_ff;
    assign req.target = target_pos;
    assign req.abs_rel = ctrl_word[`CW_ABS_REL];
    assign req.base_fb = ctrl_word[`CW_INC_BASE];
    assign req.push = ctrl_word[`CW_PUSH];
    assign req.wrap = ctrl_word[`CW_WRAP];
    assign req.wrap_mode = wrap_mode;
    // A wrap request without the wrap function enabled is refused.
    assign wrap_ok = ~req.wrap | wrap_enable; // see (RQ10)
    assign accept = new_sp_evt & op_enabled & wrap_ok & ~stop_cond;

    // ======================================================================
    // Sequencing decisions
    assign in_idle = (state_ff == ST_IDLE);
    assign in_move = (state_ff == ST_MOVING);
    assign in_stop = (state_ff == ST_STOPPING);
    assign abort_now = in_move & (stop_cond | ~op_enabled); // see (RQ7)
    assign idle_launch = in_idle & accept; // see (RQ1)
    assign imm_launch = in_move & ~abort_now & ~traj_done & accept
        & ctrl_word[`CW_CHANGE_NOW]; // see (RQ2)
    assign done_launch = in_move & ~abort_now & traj_done & (accept | pend_valid); // see (RQ3)
    assign queue_wr = in_move & ~abort_now & ~traj_done & accept
        & ~ctrl_word[`CW_CHANGE_NOW]; // see (RQ3)
    assign launch = idle_launch | imm_launch | done_launch;
    // A fresh setpoint at completion launches first; the stored one stays queued.
    assign use_pend = done_launch & ~accept; // see (RQ22)
    assign launch_req = use_pend ? pend_req : req;
    assign taken = (launch & ~use_pend) | queue_wr;

    cmd_store #(
        .WIDTH($bits(request_t))
    ) u_pending (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wr(queue_wr),
        .wr_data(req),
        .clr(use_pend | abort_now),
        .valid(pend_valid),
        .rd_data(pend_req)
    );

    // ======================================================================
    // Move resolution
    // The base position is sampled at launch, so a queued incremental move
    // counts from where the previous move really ended.
    assign inc_cmd_sum = cmd_pos + launch_req.target;
    assign inc_fb_sum = act_pos + launch_req.target;

    always_comb begin
        launch_cmd.push = launch_req.push;
        launch_cmd.rect_profile = launch_req.push; // see (RQ5)
        launch_cmd.velocity = profile_vel; // see (RQ5)
        // Range and offset pass on unscaled; the wrap coordinate logic owns the units.
        launch_cmd.wrap_range = wrap_range; // see (RQ18)
        launch_cmd.wrap_offset = wrap_offset; // see (RQ18)
        launch_cmd.dest = launch_req.target; // see (RQ13) (RQ16)
        launch_cmd.kind = KIND_ABS;
        if (launch_req.wrap) begin
            unique case (launch_req.wrap_mode) // see (RQ12) (RQ9)
                `WRAP_MODE_ABS: launch_cmd.kind = KIND_WRAP_ABS; // see (RQ16)
                `WRAP_MODE_PROX: launch_cmd.kind = KIND_WRAP_PROX; // see (RQ17)
                `WRAP_MODE_FWD: launch_cmd.kind = KIND_WRAP_FWD;
                `WRAP_MODE_REV: launch_cmd.kind = KIND_WRAP_REV;
            endcase
        end else if (launch_req.abs_rel) begin
            if (launch_req.base_fb) begin
                launch_cmd.kind = KIND_INC_FB; // see (RQ11)
                launch_cmd.dest = inc_fb_sum; // see (RQ15)
            end else begin
                launch_cmd.kind = KIND_INC_CMD; // see (RQ11)
                launch_cmd.dest = inc_cmd_sum; // see (RQ14)
            end
        end
    end

    // ======================================================================
    // State register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (idle_launch) begin
                        state_ff <= ST_MOVING;
                    end
                end
                ST_MOVING: begin
                    if (abort_now) begin
                        state_ff <= ST_STOPPING;
                    end else if (traj_done & ~done_launch) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_STOPPING: begin
                    if (traj_done) begin
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ======================================================================
    // Trajectory outputs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            move_start_ff <= 1'b0;
            move_abort_ff <= 1'b0;
            move_cmd_ff <= '0;
        end else begin
            move_start_ff <= launch; // see (RQ1) (RQ2)
            move_abort_ff <= abort_now; // see (RQ7)
            if (launch) begin
                move_cmd_ff <= launch_cmd; // see (RQ4)
            end
        end
    end

    // ======================================================================
    // Push and contact tracking
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            push_active_ff <= 1'b0;
        end else if (abort_now) begin
            push_active_ff <= 1'b0; // see (RQ7)
        end else if (launch) begin
            push_active_ff <= launch_req.push; // see (RQ4)
        end else if (in_move & traj_done) begin
            push_active_ff <= 1'b0; // see (RQ8)
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            press_ff <= 1'b0;
        end else if (launch | abort_now) begin
            press_ff <= 1'b0; // see (RQ7)
        end else if (in_move & push_active_ff & press_detect) begin
            press_ff <= 1'b1; // see (RQ6)
        end
    end

    // ======================================================================
    // Status flags
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ack_ff <= 1'b0;
        end else if (taken) begin
            ack_ff <= 1'b1; // see (RQ19)
        end else if (~ctrl_word[`CW_NEW_SETPOINT] | ~op_enabled) begin
            ack_ff <= 1'b0; // see (RQ19)
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reached_ff <= 1'b0;
        end else if (launch) begin
            reached_ff <= 1'b0; // see (RQ20)
        end else if (in_move & traj_done & ~abort_now) begin
            reached_ff <= 1'b1; // see (RQ20) (RQ8)
        end else if (in_stop & traj_done & halt) begin
            reached_ff <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            status_word_ff <= `STATUS_WORD_RESET;
        end else begin
            status_word_ff <= drive_status_in;
            status_word_ff[`SW_TARGET_REACHED] <= reached_ff;
            status_word_ff[`SW_SETPOINT_ACK] <= ack_ff;
            status_word_ff[`SW_PRESS_CONTACT] <= press_ff; // see (RQ6)
        end
    end

    // ======================================================================
    // Assertions
    property p_start_on_edge;
        @(posedge core_clk) disable iff (sys_rst)
        in_idle & accept |=> move_start_ff && (state_ff == ST_MOVING);
    endproperty
    a_start_on_edge: assert property (p_start_on_edge) else $error("no start on setpoint"); // (RQ1)

    property p_hold_no_restart;
        @(posedge core_clk) disable iff (sys_rst)
        in_idle & ctrl_word[`CW_NEW_SETPOINT] & new_sp_prev_ff |=> ~move_start_ff;
    endproperty
    a_hold_no_restart: assert property (p_hold_no_restart) else $error("held bit restarted"); // (RQ21)

    property p_immediate;
        @(posedge core_clk) disable iff (sys_rst)
        imm_launch |=> move_start_ff && (move_cmd_ff.dest == $past(launch_cmd.dest));
    endproperty
    a_immediate: assert property (p_immediate) else $error("immediate change not applied"); // (RQ2)

    property p_queue;
        @(posedge core_clk) disable iff (sys_rst)
        queue_wr |=> pend_valid && !move_start_ff && (pend_req.target == $past(target_pos));
    endproperty
    a_queue: assert property (p_queue) else $error("setpoint not queued"); // (RQ3)

    property p_push_profile;
        @(posedge core_clk) disable iff (sys_rst)
        launch & launch_req.push |=> move_cmd_ff.push && move_cmd_ff.rect_profile
            && (move_cmd_ff.velocity == $past(profile_vel)) && push_active_ff;
    endproperty
    a_push_profile: assert property (p_push_profile) else $error("push move malformed"); // (RQ5)

    property p_press;
        @(posedge core_clk) disable iff (sys_rst)
        in_move & push_active_ff & press_detect & ~launch & ~abort_now
            |-> ##2 status_word_ff[`SW_PRESS_CONTACT];
    endproperty
    a_press: assert property (p_press) else $error("press contact not reported"); // (RQ6)

    property p_halt_push;
        @(posedge core_clk) disable iff (sys_rst)
        in_move & push_active_ff & stop_cond
            |=> move_abort_ff && !push_active_ff && !press_ff && (state_ff == ST_STOPPING);
    endproperty
    a_halt_push: assert property (p_halt_push) else $error("halt did not cancel push"); // (RQ7)

    property p_push_no_contact;
        @(posedge core_clk) disable iff (sys_rst)
        in_move & push_active_ff & traj_done & ~abort_now & ~launch & ~press_ff & ~press_detect
            |-> ##2 status_word_ff[`SW_TARGET_REACHED] && !status_word_ff[`SW_PRESS_CONTACT];
    endproperty
    a_push_no_contact: assert property (p_push_no_contact) else $error("push end wrong"); // (RQ8)

    property p_wrap_kind;
        @(posedge core_clk) disable iff (sys_rst)
        launch & launch_req.wrap |=> move_cmd_ff.kind inside {KIND_WRAP_ABS, KIND_WRAP_PROX,
            KIND_WRAP_FWD, KIND_WRAP_REV};
    endproperty
    a_wrap_kind: assert property (p_wrap_kind) else $error("wrap decoded as plain move"); // (RQ9)

    property p_wrap_refused;
        @(posedge core_clk) disable iff (sys_rst)
        in_idle & ctrl_word[`CW_WRAP] & ~wrap_enable |=> ~move_start_ff;
    endproperty
    a_wrap_refused: assert property (p_wrap_refused) else $error("wrap ran while disabled"); // (RQ10)

    property p_inc_cmd;
        @(posedge core_clk) disable iff (sys_rst)
        launch & ~launch_req.wrap & launch_req.abs_rel & ~launch_req.base_fb
            |=> (move_cmd_ff.kind == KIND_INC_CMD) && (move_cmd_ff.dest == $past(inc_cmd_sum));
    endproperty
    a_inc_cmd: assert property (p_inc_cmd) else $error("bad command-based increment"); // (RQ14)

    property p_inc_fb;
        @(posedge core_clk) disable iff (sys_rst)
        launch & ~launch_req.wrap & launch_req.abs_rel & launch_req.base_fb
            |=> (move_cmd_ff.kind == KIND_INC_FB) && (move_cmd_ff.dest == $past(inc_fb_sum));
    endproperty
    a_inc_fb: assert property (p_inc_fb) else $error("bad feedback-based increment"); // (RQ15)

    property p_ack;
        @(posedge core_clk) disable iff (sys_rst)
        taken |-> ##2 status_word_ff[`SW_SETPOINT_ACK];
    endproperty
    a_ack: assert property (p_ack) else $error("setpoint not acknowledged"); // (RQ19)

    property p_ack_clear;
        @(posedge core_clk) disable iff (sys_rst)
        ~ctrl_word[`CW_NEW_SETPOINT] |=> ~ack_ff;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("acknowledge not cleared"); // (RQ19)

    property p_reached_clear;
        @(posedge core_clk) disable iff (sys_rst)
        launch |=> ~reached_ff;
    endproperty
    a_reached_clear: assert property (p_reached_clear) else $error("reached not cleared"); // (RQ20)

    c_push_contact: cover property (@(posedge core_clk) disable iff (sys_rst)
        push_active_ff & press_ff ##1 traj_done);
    c_queued_launch: cover property (@(posedge core_clk) disable iff (sys_rst)
        queue_wr ##[1:50] use_pend);
    c_immediate: cover property (@(posedge core_clk) disable iff (sys_rst) imm_launch);
    c_halt_push: cover property (@(posedge core_clk) disable iff (sys_rst)
        abort_now & push_active_ff);

endmodule
